//--- hw/ccio_regs.svh
// How it works
// - direction reads input for lines a-c, output otherwise
// - invert flag complements selected output source
// - frame, row, exposure activity routable to output
// - soft source follows software written bit
// - user timer active routable to output
// - strobe generator pulse routable to output
// - timed mode pulse width equals programmed width
// - trigger width mode copies trigger pulse width
// - strobe delayed 0 to 1000 us
// - timed width programmable 1 to 1000 us
// - exposure activity spans exposure start to end
// - level valid only after stable debounce time
// - filtered edge lags pin by debounce time (one cycle at minimum) plus two synchroniser cycles
// - pulses shorter than debounce time are dropped
`ifndef CCIO_REGS_SVH
`define CCIO_REGS_SVH

// ----------------------------------------
// timing
// ----------------------------------------
`define CCIO_CLK_HZ 10000000
`define CCIO_STEP_US 1
`define CCIO_CYC_PER_US ((`CCIO_CLK_HZ / 1000000) * `CCIO_STEP_US)
`define CCIO_US_MAX 1000
`define CCIO_CNT_W 14

// ----------------------------------------
// register offsets
// ----------------------------------------
`define CCIO_OFF_CTRL 8'h00
`define CCIO_OFF_DELAY 8'h04
`define CCIO_OFF_WIDTH 8'h08
`define CCIO_OFF_DEBOUNCE 8'h0C
`define CCIO_OFF_STATUS 8'h10

// ----------------------------------------
// control fields
// ----------------------------------------
`define CCIO_CTRL_SEL_LSB 0
`define CCIO_CTRL_INV_BIT 2
`define CCIO_CTRL_SRC_LSB 3
`define CCIO_CTRL_SOFT_BIT 6
`define CCIO_CTRL_MODE_BIT 7

// ----------------------------------------
// status fields
// ----------------------------------------
`define CCIO_STAT_DIR_BIT 0
`define CCIO_STAT_IN_LSB 1
`define CCIO_STAT_OUT_BIT 4
`define CCIO_STAT_FLASH_BIT 5
`define CCIO_STAT_EXP_BIT 6

// ----------------------------------------
// reset values
// ----------------------------------------
`define CCIO_RST_DELAY 10'h000
`define CCIO_RST_WIDTH 10'h001
`define CCIO_RST_DEBOUNCE 10'h000

`endif

//--- hw/ccio_pkg.sv
package ccio_pkg;

	typedef enum logic [2:0] {
		SRC_OFF = 3'b000,
		SRC_HIGH = 3'b001,
		SRC_FRAME = 3'b010,
		SRC_ROW = 3'b011,
		SRC_EXPOSURE = 3'b100,
		SRC_SOFT = 3'b101,
		SRC_TIMER = 3'b110,
		SRC_FLASH = 3'b111
	} ccio_source_type;

	typedef enum logic [1:0] {
		LINE_IN_A = 2'b00,
		LINE_IN_B = 2'b01,
		LINE_IN_C = 2'b10,
		LINE_OUT_A = 2'b11
	} ccio_line_type;

	typedef enum logic [1:0] {
		FL_IDLE = 2'b00,
		FL_DELAY = 2'b01,
		FL_PULSE = 2'b10
	} ccio_flash_state_type;

endpackage

//--- hw/ccio_debounce.sv
`timescale 1ns/10ps
`include "ccio_regs.svh"

module ccio_debounce
	import ccio_pkg::*;
#(
	parameter int CNT_W = `CCIO_CNT_W
)
(
	input wire logic clk, // system clock
	input wire logic rst, // synchronised reset, active high
	input wire logic pinIn, // raw pin level
	input wire logic [CNT_W-1:0] limit, // debounce time in cycles
	output logic filtered // validated level
);

	logic syncA;
	logic syncB;
	logic [CNT_W-1:0] stableCnt;

	// ----------------------------------------
	// pin synchroniser
	// ----------------------------------------
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			syncA <= 1'b0;
			syncB <= 1'b0;
		end
		else
		begin
			syncA <= pinIn;
			syncB <= syncA;
		end
	end

	// ----------------------------------------
	// stability counter
	// ----------------------------------------
	// short pulses dropped
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			stableCnt <= '0;
		else if (syncB == filtered)
			stableCnt <= '0;
		else
			stableCnt <= stableCnt + 1'b1;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			filtered <= 1'b0;
		else if (syncB != filtered && stableCnt + 1'b1 >= limit)
			filtered <= syncB;
	end

endmodule // ccio_debounce

//--- hw/ccio_top.sv
`timescale 1ns/10ps
`include "ccio_regs.svh"

module ccio_top
	import ccio_pkg::*;
#(
	parameter int CNT_W = `CCIO_CNT_W,
	parameter int NUM_IN = 3
)
(
	input wire logic clk, // system clock, 10 MHz
	input wire logic rstn, // asynchronous reset, active low
	input wire logic hsel, // ahb slave select
	input wire logic [31:0] haddr, // ahb address
	input wire logic [1:0] htrans, // ahb transfer type
	input wire logic hwrite, // ahb write
	input wire logic [2:0] hsize, // ahb size, word only
	input wire logic [31:0] hwdata, // ahb write data
	input wire logic hready, // ahb bus ready
	output logic hreadyout, // slave ready
	output logic hresp, // slave response
	output logic [31:0] hrdata, // read data
	input wire logic inputLineA, // input pin a
	input wire logic inputLineB, // input pin b
	input wire logic inputLineC, // input pin c
	output logic outputLineA, // output pin
	input wire logic frameInProgress, // frame activity
	input wire logic rowInProgress, // row activity
	input wire logic exposureStart, // exposure begin pulse
	input wire logic exposureEnd, // exposure end pulse
	input wire logic userTimerActive, // timer activity
	output logic [NUM_IN-1:0] filteredLines // debounced inputs
);

	// ----------------------------------------
	// reset release
	// ----------------------------------------
	logic [1:0] rstPipe;
	logic rst;

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			rstPipe <= 2'b00;
		else
			rstPipe <= {rstPipe[0], 1'b1};
	end

	assign rst = ~rstPipe[1];

	// ----------------------------------------
	// configuration state
	// ----------------------------------------
	ccio_line_type ioLineSelect;
	logic outputInvert;
	ccio_source_type outputSourceSelect;
	logic softOutputBit;
	logic followTriggerWidthMode;
	logic [9:0] flashPulseDelay;
	logic [9:0] flashPulseWidth;
	logic [9:0] debounceTime;
	logic exposureInProgress;
	logic flashPulseZero;
	logic ioLineDirection;

	// ----------------------------------------
	// bus address phase capture
	// ----------------------------------------
	logic wrPend;
	logic [7:0] wrAddr;
	logic addrPhase;

	assign addrPhase = hsel && htrans[1] && hready;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			wrPend <= 1'b0;
			wrAddr <= 8'h00;
		end
		else
		begin
			wrPend <= addrPhase && hwrite;
			wrAddr <= haddr[7:0];
		end
	end

	// ----------------------------------------
	// register writes
	// ----------------------------------------
	logic [9:0] next_delay;
	logic [9:0] next_width;

	always_comb
	begin
		next_delay = hwdata[9:0];
		if (next_delay > 10'(`CCIO_US_MAX))
			next_delay = 10'(`CCIO_US_MAX);
		next_width = hwdata[9:0];
		if (next_width > 10'(`CCIO_US_MAX))
			next_width = 10'(`CCIO_US_MAX);
		else if (next_width == 10'h000)
			next_width = 10'h001;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			ioLineSelect <= LINE_IN_A;
			outputInvert <= 1'b0;
			outputSourceSelect <= SRC_OFF;
			softOutputBit <= 1'b0;
			followTriggerWidthMode <= 1'b0;
		end
		else if (wrPend && wrAddr == `CCIO_OFF_CTRL)
		begin
			ioLineSelect <= ccio_line_type'(hwdata[`CCIO_CTRL_SEL_LSB +: 2]);
			outputInvert <= hwdata[`CCIO_CTRL_INV_BIT];
			outputSourceSelect <= ccio_source_type'(hwdata[`CCIO_CTRL_SRC_LSB +: 3]);
			softOutputBit <= hwdata[`CCIO_CTRL_SOFT_BIT];
			followTriggerWidthMode <= hwdata[`CCIO_CTRL_MODE_BIT];
		end
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			flashPulseDelay <= `CCIO_RST_DELAY;
			flashPulseWidth <= `CCIO_RST_WIDTH;
			debounceTime <= `CCIO_RST_DEBOUNCE;
		end
		else if (wrPend)
		begin
			if (wrAddr == `CCIO_OFF_DELAY)
				flashPulseDelay <= next_delay;
			if (wrAddr == `CCIO_OFF_WIDTH)
				flashPulseWidth <= next_width;
			if (wrAddr == `CCIO_OFF_DEBOUNCE)
				debounceTime <= hwdata[9:0];
		end
	end

	// ----------------------------------------
	// register reads
	// ----------------------------------------
	logic [31:0] next_rdata;

	assign ioLineDirection = (ioLineSelect == LINE_OUT_A);

	always_comb
	begin
		next_rdata = 32'h0000_0000;
		unique case (haddr[7:0])
			`CCIO_OFF_CTRL:
			begin
				next_rdata[`CCIO_CTRL_SEL_LSB +: 2] = ioLineSelect;
				next_rdata[`CCIO_CTRL_INV_BIT] = outputInvert;
				next_rdata[`CCIO_CTRL_SRC_LSB +: 3] = outputSourceSelect;
				next_rdata[`CCIO_CTRL_SOFT_BIT] = softOutputBit;
				next_rdata[`CCIO_CTRL_MODE_BIT] = followTriggerWidthMode;
			end
			`CCIO_OFF_DELAY: next_rdata[9:0] = flashPulseDelay;
			`CCIO_OFF_WIDTH: next_rdata[9:0] = flashPulseWidth;
			`CCIO_OFF_DEBOUNCE: next_rdata[9:0] = debounceTime;
			`CCIO_OFF_STATUS:
			begin
				next_rdata[`CCIO_STAT_DIR_BIT] = ioLineDirection;
				next_rdata[`CCIO_STAT_IN_LSB +: 3] = filteredLines;
				next_rdata[`CCIO_STAT_OUT_BIT] = outputLineA;
				next_rdata[`CCIO_STAT_FLASH_BIT] = flashPulseZero;
				next_rdata[`CCIO_STAT_EXP_BIT] = exposureInProgress;
			end
			default: next_rdata = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			hrdata <= 32'h0000_0000;
		else if (addrPhase && !hwrite)
			hrdata <= next_rdata;
	end

	// ----------------------------------------
	// input filters
	// ----------------------------------------
	logic [NUM_IN-1:0] rawLines;
	logic [CNT_W-1:0] debounceCycles;

	assign rawLines = {inputLineC, inputLineB, inputLineA};
	assign debounceCycles = CNT_W'(debounceTime * `CCIO_CYC_PER_US);

	genvar gi;
	generate
		for (gi = 0; gi < NUM_IN; gi++)
		begin : g_in
			ccio_debounce #(
				.CNT_W(CNT_W)
			) u_deb (
				.clk(clk),
				.rst(rst),
				.pinIn(rawLines[gi]),
				.limit(debounceCycles),
				.filtered(filteredLines[gi])
			);
		end
	endgenerate

	// ----------------------------------------
	// exposure activity
	// ----------------------------------------
	// start sets, end clears
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			exposureInProgress <= 1'b0;
		else if (exposureStart)
			exposureInProgress <= 1'b1;
		else if (exposureEnd)
			exposureInProgress <= 1'b0;
	end

	// ----------------------------------------
	// trigger edges
	// ----------------------------------------
	logic trigPrev;
	logic trigRise;
	logic trigFall;

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			trigPrev <= 1'b0;
		else
			trigPrev <= filteredLines[0];
	end

	assign trigRise = filteredLines[0] && !trigPrev;
	assign trigFall = !filteredLines[0] && trigPrev;

	// ----------------------------------------
	// delayed trigger end
	// ----------------------------------------
	logic [CNT_W-1:0] delayCycles;
	logic [CNT_W-1:0] widthCycles;
	logic [CNT_W-1:0] fallCnt;
	logic fallPend;
	logic fallDone;

	assign delayCycles = CNT_W'(flashPulseDelay * `CCIO_CYC_PER_US);
	assign widthCycles = CNT_W'(flashPulseWidth * `CCIO_CYC_PER_US);

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			fallPend <= 1'b0;
			fallCnt <= '0;
		end
		else if (trigFall)
		begin
			fallPend <= 1'b1;
			fallCnt <= '0;
		end
		else if (fallPend)
		begin
			fallCnt <= fallCnt + 1'b1;
			if (fallCnt + 1'b1 >= delayCycles)
				fallPend <= 1'b0;
		end
	end

	assign fallDone = (trigFall && delayCycles == '0)
		|| (fallPend && !trigFall && fallCnt + 1'b1 >= delayCycles);

	// ----------------------------------------
	// strobe generator
	// ----------------------------------------
	ccio_flash_state_type flashState;
	logic [CNT_W-1:0] flashCnt;

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			flashState <= FL_IDLE;
			flashCnt <= '0;
		end
		else
		begin
			unique case (flashState)
				FL_IDLE:
				begin
					flashCnt <= '0;
					if (trigRise)
						flashState <= (delayCycles == '0) ? FL_PULSE : FL_DELAY;
				end
				FL_DELAY:
				begin
					flashCnt <= flashCnt + 1'b1;
					if (flashCnt + 1'b1 >= delayCycles)
					begin
						flashState <= FL_PULSE;
						flashCnt <= '0;
					end
				end
				FL_PULSE:
				begin
					flashCnt <= flashCnt + 1'b1;
					if (!followTriggerWidthMode && flashCnt + 1'b1 >= widthCycles)
						flashState <= FL_IDLE;
					else if (followTriggerWidthMode && fallDone)
						flashState <= FL_IDLE;
				end
				default:
					flashState <= FL_IDLE;
			endcase
		end
	end

	assign flashPulseZero = (flashState == FL_PULSE);

	// ----------------------------------------
	// output source and inversion
	// ----------------------------------------
	logic srcLevel;
	logic next_outputLine;

	always_comb
	begin
		srcLevel = 1'b0;
		unique case (outputSourceSelect)
			SRC_OFF: srcLevel = 1'b0;
			SRC_HIGH: srcLevel = 1'b1;
			SRC_FRAME: srcLevel = frameInProgress;
			SRC_ROW: srcLevel = rowInProgress;
			SRC_EXPOSURE: srcLevel = exposureInProgress;
			SRC_SOFT: srcLevel = softOutputBit;
			SRC_TIMER: srcLevel = userTimerActive;
			SRC_FLASH: srcLevel = flashPulseZero;
		endcase
	end

	assign next_outputLine = srcLevel ^ outputInvert;

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			outputLineA <= 1'b0;
		else
			outputLineA <= next_outputLine;
	end

endmodule // ccio_top

//--- testbench/ccio_equipment.sv
`timescale 1ns/10ps
module ccio_equipment
(
	input wire logic clk, // clock
	output logic [2:0] lines // pins c b a
);
	initial lines = 3'h0;
	// ----------------------------------------
	// connector pin drive
	// ----------------------------------------
	task automatic pulse(input int i, input logic v, input int n);
		lines[i] <= v;
		repeat (n) @(posedge clk);
		lines[i] <= !v;
	endtask
	task automatic set(input int i, input logic v);
		lines[i] <= v;
	endtask
endmodule // ccio_equipment

//--- testbench/ccio_monitor.sv
`timescale 1ns/10ps
module ccio_monitor
	import ccio_pkg::*;
#(
	parameter int NUM_IN = 3
)
(
	input wire logic clk, // clock
	input wire logic rstn, // reset
	input wire logic hsel, // sel
	input wire logic [31:0] haddr, // addr
	input wire logic [1:0] htrans, // trans
	input wire logic hwrite, // write
	input wire logic hready, // ready
	input wire logic [31:0] hwdata, // wdata
	input wire logic hreadyout, // ready out
	input wire logic hresp, // resp
	input wire logic inputLineA, // pin a
	input wire logic inputLineB, // pin b
	input wire logic inputLineC, // pin c
	input wire logic frameInProgress, // frame
	input wire logic rowInProgress, // row
	input wire logic userTimerActive, // timer
	input wire logic outputLineA, // out pin
	input wire logic [NUM_IN-1:0] filteredLines // filtered
);
	// ----------------------------------------
	// shadow of the control word
	// ----------------------------------------
	logic wrCtrl;
	logic [7:0] ctrl;
	logic [7:0] pc;
	logic [2:0] src;
	logic inv;
	logic [NUM_IN-1:0] pins;
	logic inReset;
	assign src = pc[5:3];
	assign inv = pc[2];
	assign pins = NUM_IN'({inputLineC, inputLineB, inputLineA});
	always_ff @(posedge clk or negedge rstn)
		if (!rstn)
		begin
			wrCtrl <= 1'b0;
			ctrl <= 8'h00;
			pc <= 8'h00;
		end
		else
		begin
			wrCtrl <= hsel && htrans[1] && hready && hwrite && haddr[7:0] == 8'h00;
			pc <= ctrl;
			if (wrCtrl)
				ctrl <= hwdata[7:0];
		end
	// reset seen for a full cycle, so outputs have had an edge to clear
	always_ff @(posedge clk)
		inReset <= !rstn;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);
	a_bus_okay: assert property (hreadyout && !hresp)
		else $error("bus answer wrong");
	a_reset_quiet: assert property (disable iff (1'b0)
		!rstn && inReset |-> !outputLineA && filteredLines == '0) else $error("outputs active in reset");
	a_filter_lag: assert property (
		((filteredLines ^ $past(filteredLines)) & (filteredLines ^ $past(pins, 3))) == '0)
		else $error("filtered edge without stable pin");
	a_src_fixed: assert property (
		pc == $past(pc) && src[2:1] == 2'b00 |-> outputLineA == (src[0] ^ inv))
		else $error("off or high level wrong");
	a_src_frame: assert property (
		pc == $past(pc) && src == SRC_FRAME |-> outputLineA == ($past(frameInProgress) ^ inv))
		else $error("frame routing wrong");
	a_src_row: assert property (
		pc == $past(pc) && src == SRC_ROW |-> outputLineA == ($past(rowInProgress) ^ inv))
		else $error("row routing wrong");
	a_src_timer: assert property (
		pc == $past(pc) && src == SRC_TIMER |-> outputLineA == ($past(userTimerActive) ^ inv))
		else $error("timer routing wrong");
	a_src_soft: assert property (
		pc == $past(pc) && src == SRC_SOFT |-> outputLineA == (pc[6] ^ inv))
		else $error("soft bit routing wrong");
endmodule // ccio_monitor

bind ccio_top ccio_monitor #(.NUM_IN(NUM_IN)) i_ccio_monitor (.clk, .rstn, .hsel, .haddr,
	.htrans, .hwrite, .hready, .hwdata, .hreadyout, .hresp, .inputLineA, .inputLineB,
	.inputLineC, .frameInProgress, .rowInProgress, .userTimerActive, .outputLineA,
	.filteredLines);

//--- testbench/camera_control_io_strobe_debounce_tb.sv
`timescale 1ns/10ps
module camera_control_io_strobe_debounce_tb;
	logic clk = 1'b0, rstn = 1'b0, hsel = 1'b0, hwrite = 1'b0, e;
	logic frameInProgress = 1'b0, rowInProgress = 1'b0, userTimerActive = 1'b0;
	logic exposureStart = 1'b0, exposureEnd = 1'b0, hreadyout, hresp, outputLineA;
	logic [1:0] htrans = 2'h0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q;
	logic [2:0] filteredLines;
	wire [2:0] lines;
	logic [7:0] rAddr [6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h20};
	int n_fail = 0, checks_done = 0, cyc = 0, a, b, c;
	ccio_top i_ccio_top (.clk, .rstn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
		.hready(hreadyout), .hreadyout, .hresp, .hrdata, .inputLineA(lines[0]),
		.inputLineB(lines[1]), .inputLineC(lines[2]), .outputLineA, .frameInProgress,
		.rowInProgress, .exposureStart, .exposureEnd, .userTimerActive, .filteredLines);
	ccio_equipment i_ccio_equipment (.clk, .lines);
	initial
		forever #50 clk = ~clk;
	// ----------------------------------------
	// compare, bus and timing tasks
	// ----------------------------------------
	task automatic check(input string nm, input logic [31:0] s, x);
		checks_done++;
		if (s !== x)
		begin
			n_fail++;
			$display("[FAIL] %s exp %h seen %h", nm, x, s);
		end
	endtask
	task automatic end_sim();
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic ahb(input logic w, input logic [7:0] ad, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, ad};
		@(posedge clk);
		while (hreadyout !== 1'b1)
			@(posedge clk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge clk);
		while (hreadyout !== 1'b1)
			@(posedge clk);
		q = hrdata;
	endtask
	task automatic rdc(input logic [7:0] ad, input logic [31:0] x);
		ahb(1'b0, ad, 32'h0);
		check($sformatf("reg %h", ad), q, x);
	endtask
	// counts settled cycles until a line reaches a level, 3 selects the output pin
	task automatic waitc(input int i, input logic v, output int n);
		n = 0;
		while (((i == 3) ? outputLineA : filteredLines[i]) !== v)
		begin
			@(negedge clk);
			n++;
		end
	endtask
	task automatic flash(input logic [31:0] d, w, input logic m, input int h, ew);
		ahb(1'b1, 8'h04, d);
		ahb(1'b1, 8'h08, w);
		ahb(1'b1, 8'h00, {24'h0, m, 7'h3B});
		fork
			i_ccio_equipment.pulse(0, 1'b1, h);
			begin
				waitc(0, 1'b1, a);
				waitc(3, 1'b1, b);
				waitc(3, 1'b0, c);
			end
		join
		// one cycle for the strobe state register, one for the registered pin
		check("strobe delay", b, d * 10 + 2);
		check("strobe width", c, ew);
		@(posedge clk);
	endtask
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			n_fail++;
			end_sim();
		end
	end
	// ----------------------------------------
	// test sequence
	// ----------------------------------------
	initial
	begin
		repeat (5) @(posedge clk);
		rstn <= 1'b1;
		repeat (3) @(posedge clk);
		ahb(1'b1, 8'h20, 32'hFFFFFFFF);
		for (int i = 0; i < 6; i++)
			rdc(rAddr[i], 32'(i == 2));
		for (int s = 0; s < 4; s++)
		begin
			ahb(1'b1, 8'h00, 32'(s));
			rdc(8'h10, 32'(s == 3));
		end
		for (int v = 0; v < 2; v++)
			for (int s = 0; s < 7; s++)
				for (int p = 0; p < 2; p++)
					if (s != 4)
					begin
						frameInProgress <= p[0];
						rowInProgress <= !p[0];
						userTimerActive <= p[0];
						ahb(1'b1, 8'h00, {24'h0, 1'b0, !p[0], 3'(s), v[0], 2'h3});
						repeat (3) @(posedge clk);
						e = (s == 1) || ((s == 2 || s == 6) && p[0]) || ((s == 3 || s == 5) && !p[0]);
						check("source", outputLineA, e ^ v[0]);
					end
		ahb(1'b1, 8'h00, 32'h23);
		for (int k = 0; k < 2; k++)
		begin
			exposureStart <= (k == 0);
			exposureEnd <= (k == 1);
			@(posedge clk);
			exposureStart <= 1'b0;
			exposureEnd <= 1'b0;
			repeat (3) @(posedge clk);
			check("exposure", outputLineA, k == 0);
			rdc(8'h10, (k == 0) ? 32'h51 : 32'h01);
		end
		ahb(1'b1, 8'h0C, 32'h2);
		i_ccio_equipment.pulse(1, 1'b1, 19);
		repeat (30) @(posedge clk);
		check("short high", filteredLines, 32'h0);
		i_ccio_equipment.set(1, 1'b1);
		waitc(1, 1'b1, a);
		check("filter lag", a, 23);
		@(posedge clk);
		i_ccio_equipment.pulse(1, 1'b0, 19);
		repeat (30) @(posedge clk);
		rdc(8'h10, 32'h05);
		i_ccio_equipment.set(1, 1'b0);
		ahb(1'b1, 8'h0C, 32'h0);
		ahb(1'b1, 8'h04, 32'h3FF);
		rdc(8'h04, 32'h3E8);
		ahb(1'b1, 8'h08, 32'h0);
		rdc(8'h08, 32'h1);
		flash(32'h1, 32'h2, 1'b0, 5, 20);
		flash(32'h0, 32'h1, 1'b0, 3, 10);
		flash(32'h2, 32'h5, 1'b1, 25, 25);
		end_sim();
	end
endmodule // camera_control_io_strobe_debounce_tb
